// ===== event_cfg_pkg.sv
// constants for the event status, link configuration and error counter group
// assumes a 16-bit register view placed in the low bits of a 32-bit avalon word
package event_cfg_pkg;
  // ----------------------------------------
  // register word indices and address width
  // ----------------------------------------
  localparam logic [5:0] EVENT_STATUS_IDX = 6'h13;
  localparam logic [5:0] EVENT_ENABLE_IDX = 6'h12;
  localparam logic [5:0] LINK_CONFIG_TWO_IDX = 6'h14;
  localparam logic [5:0] RX_FAULT_COUNT_IDX = 6'h15;
  localparam int ADDR_W = 8;
  // ----------------------------------------
  // event status bit positions
  // ----------------------------------------
  localparam int NEGOTIATION_FAULT_BIT = 15;
  localparam int RATE_CHANGE_BIT = 14;
  localparam int DUPLEX_CHANGE_BIT = 13;
  localparam int PAGE_RECEIVED_BIT = 12;
  localparam int NEGOTIATION_DONE_BIT = 11;
  localparam int LINK_CHANGE_BIT = 10;
  localparam int FALSE_CARRIER_BIT = 8;
  localparam int PAIR_SWAP_CHANGE_BIT = 6;
  localparam int DOWNSHIFT_EVENT_BIT = 5;
  localparam int DOZE_CHANGE_BIT = 4;
  localparam int WAKE_PACKET_BIT = 3;
  localparam int MAC_LINK_ERROR_BIT = 2;
  localparam int LINE_INVERSION_BIT = 1;
  localparam int JABBER_BIT = 0;
  localparam logic [15:0] EVENT_VALID_MASK = 16'hfd7f;
  localparam logic [15:0] EVENT_STATUS_RESET = 16'h0000;
  localparam logic [15:0] EVENT_ENABLE_RESET = 16'h0000;
  // ----------------------------------------
  // link configuration fields
  // ----------------------------------------
  localparam int IRQ_POLARITY_BIT = 13;
  localparam int RETRY_LIMIT_HI = 11;
  localparam int RETRY_LIMIT_LO = 10;
  localparam int DOWNSHIFT_ENABLE_BIT = 9;
  localparam int ENERGY_MODE_BIT = 8;
  localparam int SERIAL_NEG_BIT = 7;
  localparam int TEN_ENABLE_BIT = 6;
  localparam logic IRQ_POLARITY_RESET = 1'b1;
  localparam logic [1:0] RETRY_LIMIT_RESET = 2'h2;
  localparam logic ENERGY_MODE_RESET = 1'b1;
  localparam logic SERIAL_NEG_RESET = 1'b1;
  localparam logic TEN_ENABLE_RESET = 1'b1;
  localparam logic [5:0] CONFIG_LOW_FIXED = 6'h07;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ===== sat_counter.sv
// saturating event counter with synchronous clear
// assumes clear and increment come from logic on the same clock
`timescale 1ns/1ps
module sat_counter
  import event_cfg_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // control
  input wire logic clear_i,
  input wire logic incr_i,
  // count
  output logic [15:0] count_o
);
  logic [15:0] count_q;
  logic [15:0] count_d;
  wire at_max = (count_q == COUNT_MAX);
  // clear has priority: an error in the clear cycle is dropped
  assign count_d = clear_i ? 16'h0000 : ((incr_i && !at_max) ? count_q + 16'h0001 : count_q);
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end
  assign count_o = count_q;

  AST_NO_WRAP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (count_q == COUNT_MAX && !clear_i) |=> count_q == COUNT_MAX)
    else $error("counter wrapped");
  AST_CLEARS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    clear_i |=> count_q == 16'h0000)
    else $error("counter not cleared");
endmodule

// ===== phy_event_status_and_config.sv
// event status, link configuration two and receive error count registers
// assumes avalon-mm master on clock_i; event and strap inputs are asynchronous
`timescale 1ns/1ps
module phy_event_status_and_config
  import event_cfg_pkg::*;
#(
  parameter bit STRAP_PACKAGE = 1'b0
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // event sources, one pulse or edge per event
  input wire logic [15:0] event_i,
  input wire logic rx_error_i,
  input wire logic downshift_strap_i,
  // interrupt pin
  output logic irq_pin_o,
  // configuration outputs
  output logic [3:0] downshift_retry_limit_o,
  output logic downshift_enable_o,
  output logic downshift_energy_mode_o,
  output logic serial_mac_negotiation_enable_o,
  output logic downshift_to_ten_enable_o
);
  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic [15:0] ev_meta_q;
  logic [15:0] ev_sync_q;
  logic [15:0] ev_prev_q;
  logic rxe_meta_q;
  logic rxe_sync_q;
  logic rxe_prev_q;
  logic strap_meta_q;
  logic strap_sync_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta_q <= 16'h0000;
      ev_sync_q <= 16'h0000;
      ev_prev_q <= 16'h0000;
      rxe_meta_q <= 1'b0;
      rxe_sync_q <= 1'b0;
      rxe_prev_q <= 1'b0;
      strap_meta_q <= 1'b0;
      strap_sync_q <= 1'b0;
    end else begin
      ev_meta_q <= event_i;
      ev_sync_q <= ev_meta_q;
      ev_prev_q <= ev_sync_q;
      rxe_meta_q <= rx_error_i;
      rxe_sync_q <= rxe_meta_q;
      rxe_prev_q <= rxe_sync_q;
      strap_meta_q <= downshift_strap_i;
      strap_sync_q <= strap_meta_q;
    end
  end
  // events count on the rising edge of each synchronised source except reserved bits 9 and 7, which EVENT_VALID_MASK drops
  wire [15:0] event_pulse = ev_sync_q & ~ev_prev_q & EVENT_VALID_MASK;
  wire rx_error_pulse = rxe_sync_q & ~rxe_prev_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one wait cycle per access so read data come from a register
  logic ack_q;
  wire access = (avs_read_i || avs_write_i) && !ack_q;
  wire [5:0] word_idx = avs_address_i[7:2];
  wire hit_status = (word_idx == EVENT_STATUS_IDX);
  wire hit_enable = (word_idx == EVENT_ENABLE_IDX);
  wire hit_config = (word_idx == LINK_CONFIG_TWO_IDX);
  wire hit_count = (word_idx == RX_FAULT_COUNT_IDX);
  wire lane_lo = avs_byteenable_i[0];
  wire lane_hi = avs_byteenable_i[1];
  wire rd_status = access && avs_read_i && hit_status;
  wire wr_enable = access && avs_write_i && hit_enable;
  wire wr_config = access && avs_write_i && hit_config;
  wire wr_count = access && avs_write_i && hit_count;

  // ----------------------------------------
  // event status and enable
  // ----------------------------------------
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  // clear only what the read reported; a new event in that cycle survives
  assign status_d = (rd_status ? 16'h0000 : status_q) | event_pulse;
  wire [15:0] enable_wdata = {(lane_hi ? avs_writedata_i[15:8] : enable_q[15:8]),
                              (lane_lo ? avs_writedata_i[7:0] : enable_q[7:0])} & EVENT_VALID_MASK;
  assign enable_d = wr_enable ? enable_wdata : enable_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= EVENT_STATUS_RESET;
      enable_q <= EVENT_ENABLE_RESET;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
    end
  end

  // ----------------------------------------
  // link configuration two
  // ----------------------------------------
  logic irq_pol_q;
  logic [1:0] retry_q;
  logic ds_en_q;
  logic energy_q;
  logic serial_neg_q;
  logic ten_q;
  logic strap_taken_q;
  wire wr_cfg_hi = wr_config && lane_hi;
  wire wr_cfg_lo = wr_config && lane_lo;
  // strap_sync_q taken once, in the first cycle after reset while it still holds its reset 0, before any write can land
  wire ds_en_d = !strap_taken_q ? (STRAP_PACKAGE & strap_sync_q) :
                 wr_cfg_hi ? avs_writedata_i[DOWNSHIFT_ENABLE_BIT] : ds_en_q;
  wire irq_pol_d = wr_cfg_hi ? avs_writedata_i[IRQ_POLARITY_BIT] : irq_pol_q;
  wire [1:0] retry_d = wr_cfg_hi ? avs_writedata_i[RETRY_LIMIT_HI:RETRY_LIMIT_LO] : retry_q;
  wire energy_d = wr_cfg_hi ? avs_writedata_i[ENERGY_MODE_BIT] : energy_q;
  wire serial_neg_d = wr_cfg_lo ? avs_writedata_i[SERIAL_NEG_BIT] : serial_neg_q;
  wire ten_d = wr_cfg_lo ? avs_writedata_i[TEN_ENABLE_BIT] : ten_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_pol_q <= IRQ_POLARITY_RESET;
      retry_q <= RETRY_LIMIT_RESET;
      ds_en_q <= 1'b0;
      energy_q <= ENERGY_MODE_RESET;
      serial_neg_q <= SERIAL_NEG_RESET;
      ten_q <= TEN_ENABLE_RESET;
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
      ds_en_q <= ds_en_d;
      irq_pol_q <= irq_pol_d;
      retry_q <= retry_d;
      energy_q <= energy_d;
      serial_neg_q <= serial_neg_d;
      ten_q <= ten_d;
    end
  end
  wire [15:0] config_view = {2'b00, irq_pol_q, 1'b0, retry_q, ds_en_q, energy_q,
                             serial_neg_q, ten_q, CONFIG_LOW_FIXED};

  // ----------------------------------------
  // receive error counter
  // ----------------------------------------
  logic [15:0] count;
  sat_counter u_count (
    .clock_i(clock_i),
    .rst_b_i(rst_n),
    .clear_i(wr_count),
    .incr_i(rx_error_pulse),
    .count_o(count)
  );

  // ----------------------------------------
  // read data and handshake
  // ----------------------------------------
  wire [31:0] read_mux = hit_status ? {16'h0000, status_q} :
                         hit_enable ? {16'h0000, enable_q} :
                         hit_config ? {16'h0000, config_view} :
                         hit_count ? {16'h0000, count} : UNMAPPED_READ;
  logic [31:0] rdata_q;
  logic wait_q;
  wire [31:0] rdata_d = (access && avs_read_i) ? read_mux : rdata_q;
  // waitrequest comes straight from a flop: low only in the cycle after an access is taken
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= access;
      wait_q <= !access;
      rdata_q <= rdata_d;
    end
  end
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ----------------------------------------
  // interrupt pin and configuration outputs
  // ----------------------------------------
  wire irq_active = |(status_q & enable_q);
  logic irq_q;
  logic [3:0] limit_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= IRQ_POLARITY_RESET;
      limit_q <= 4'h1 << RETRY_LIMIT_RESET;
    end else begin
      irq_q <= irq_active ^ irq_pol_q;
      limit_q <= 4'h1 << retry_q;
    end
  end
  assign irq_pin_o = irq_q;
  assign downshift_retry_limit_o = limit_q;
  assign downshift_enable_o = ds_en_q;
  assign downshift_energy_mode_o = energy_q;
  assign serial_mac_negotiation_enable_o = serial_neg_q;
  assign downshift_to_ten_enable_o = ten_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_EVENT_SETS: assert property (@(posedge clock_i) disable iff (!rst_n)
    (event_pulse != 16'h0000) |=> ((status_q & $past(event_pulse)) == $past(event_pulse)))
    else $error("event not captured");
  AST_ONLY_EVENTS_SET: assert property (@(posedge clock_i) disable iff (!rst_n)
    !rd_status |=> ((status_q & ~$past(status_q)) == ($past(event_pulse) & ~$past(status_q))))
    else $error("status bit set without event");
  AST_NO_ENABLE_NEEDED: assert property (@(posedge clock_i) disable iff (!rst_n)
    (event_pulse[JABBER_BIT] && !enable_q[JABBER_BIT]) |=> status_q[JABBER_BIT])
    else $error("event lost while disabled");
  AST_CLEAR_ON_READ: assert property (@(posedge clock_i) disable iff (!rst_n)
    rd_status |=> ((status_q & ~$past(event_pulse)) == 16'h0000))
    else $error("status not cleared by read");
  AST_READ_RETURNS: assert property (@(posedge clock_i) disable iff (!rst_n)
    rd_status |=> rdata_q == {16'h0000, $past(status_q)})
    else $error("status read value wrong");
  AST_READ_ANSWERED: assert property (@(posedge clock_i) disable iff (!rst_n)
    rd_status |=> !avs_waitrequest_o)
    else $error("status read not answered");
  AST_RESERVED_STATUS: assert property (@(posedge clock_i) disable iff (!rst_n)
    (status_q[9] == 1'b0) && (status_q[7] == 1'b0))
    else $error("reserved status bit set");
  AST_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n)
    (status_q[DOWNSHIFT_EVENT_BIT] && !rd_status) |=> status_q[DOWNSHIFT_EVENT_BIT])
    else $error("status bit dropped without read");
  AST_LOW_EVENT_SETS: assert property (@(posedge clock_i) disable iff (!rst_n)
    event_pulse[DOZE_CHANGE_BIT] |=> status_q[DOZE_CHANGE_BIT])
    else $error("doze change not captured");
  AST_MAC_ERROR_SETS: assert property (@(posedge clock_i) disable iff (!rst_n)
    event_pulse[MAC_LINK_ERROR_BIT] |=> status_q[MAC_LINK_ERROR_BIT])
    else $error("mac link error not captured");
  AST_IRQ_POLARITY: assert property (@(posedge clock_i) disable iff (!rst_n)
    1'b1 |=> irq_pin_o == ($past(irq_active) ^ $past(irq_pol_q)))
    else $error("interrupt level wrong");
  AST_IRQ_ACTIVE_LOW: assert property (@(posedge clock_i) disable iff (!rst_n)
    (irq_pol_q && (status_q & enable_q) != 16'h0000) |=> !irq_pin_o)
    else $error("active low interrupt not driven low");
  AST_IRQ_ACTIVE_HIGH: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!irq_pol_q && (status_q & enable_q) != 16'h0000) |=> irq_pin_o)
    else $error("active high interrupt not driven high");
  AST_POLARITY_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_cfg_hi |=> irq_pol_q == $past(avs_writedata_i[IRQ_POLARITY_BIT]))
    else $error("polarity write lost");
  AST_RETRY_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_cfg_hi |=> retry_q == $past(avs_writedata_i[RETRY_LIMIT_HI:RETRY_LIMIT_LO]))
    else $error("retry field write lost");
  AST_RETRY_ONE: assert property (@(posedge clock_i) disable iff (!rst_n)
    (retry_q == 2'h0) [*2] |-> downshift_retry_limit_o == 4'h1)
    else $error("retry limit one wrong");
  AST_RETRY_TWO: assert property (@(posedge clock_i) disable iff (!rst_n)
    (retry_q == 2'h1) [*2] |-> downshift_retry_limit_o == 4'h2)
    else $error("retry limit two wrong");
  AST_RETRY_FOUR: assert property (@(posedge clock_i) disable iff (!rst_n)
    (retry_q == 2'h2) [*2] |-> downshift_retry_limit_o == 4'h4)
    else $error("retry limit four wrong");
  AST_RETRY_MAP: assert property (@(posedge clock_i) disable iff (!rst_n)
    (retry_q == 2'h3) [*2] |-> downshift_retry_limit_o == 4'h8)
    else $error("retry limit mapping wrong");
  AST_STRAP_TAKEN: assert property (@(posedge clock_i) disable iff (!rst_n)
    !strap_taken_q |=> ds_en_q == (STRAP_PACKAGE & $past(strap_sync_q)))
    else $error("downshift enable not taken from strap");
  AST_DOWNSHIFT_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n)
    (strap_taken_q && wr_cfg_hi) |=> ds_en_q == $past(avs_writedata_i[DOWNSHIFT_ENABLE_BIT]))
    else $error("downshift enable write lost");
  AST_UPPER_CONFIG_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n)
    (strap_taken_q && !wr_cfg_hi) |=> ($stable(ds_en_q) && $stable(irq_pol_q) && $stable(retry_q) && $stable(energy_q)))
    else $error("upper config changed without write");
  AST_ENERGY_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_cfg_hi |=> energy_q == $past(avs_writedata_i[ENERGY_MODE_BIT]))
    else $error("energy mode write lost");
  AST_SERIAL_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_cfg_lo |=> serial_neg_q == $past(avs_writedata_i[SERIAL_NEG_BIT]))
    else $error("serial negotiation write lost");
  AST_LOWER_CONFIG_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n)
    !wr_cfg_lo |=> ($stable(serial_neg_q) && $stable(ten_q)))
    else $error("lower config changed without write");
  AST_TEN_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_cfg_lo |=> ten_q == $past(avs_writedata_i[TEN_ENABLE_BIT]))
    else $error("ten megabit fallback write lost");
  AST_CONFIG_FIXED: assert property (@(posedge clock_i) disable iff (!rst_n)
    config_view[15:14] == 2'b00 && config_view[5:0] == CONFIG_LOW_FIXED)
    else $error("fixed config bits wrong");
  AST_ERROR_COUNTS: assert property (@(posedge clock_i) disable iff (!rst_n)
    (rx_error_pulse && !wr_count && count != COUNT_MAX) |=> count == $past(count) + 16'h0001)
    else $error("receive error not counted");
  AST_COUNT_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!rx_error_pulse && !wr_count) |=> $stable(count))
    else $error("count changed without error");
  AST_COUNT_WRITE_CLEARS: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_count |=> (!avs_waitrequest_o && count == 16'h0000))
    else $error("count write not cleared or answered");
  AST_MASKED_QUIET: assert property (@(posedge clock_i) disable iff (!rst_n)
    ((status_q & enable_q) == 16'h0000) |=> irq_pin_o == $past(irq_pol_q))
    else $error("interrupt without enabled event");
  AST_RESERVED_ENABLE: assert property (@(posedge clock_i) disable iff (!rst_n)
    (enable_q[9] == 1'b0) && (enable_q[7] == 1'b0))
    else $error("reserved enable bit set");
  AST_ENABLE_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n)
    (wr_enable && lane_lo && lane_hi) |=> enable_q == ($past(avs_writedata_i[15:0]) & EVENT_VALID_MASK))
    else $error("enable write lost");
  AST_ENABLE_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n)
    !wr_enable |=> $stable(enable_q))
    else $error("enable changed without write");
  AST_IRQ_DROPS: assert property (@(posedge clock_i) disable iff (!rst_n)
    (rd_status && event_pulse == 16'h0000) |=> ##1 irq_pin_o == $past(irq_pol_q))
    else $error("interrupt stays after clearing read");
endmodule

// ===== testbench.sv
// self-checking bench for the event status, link configuration and error count group
// assumes the event_cfg_pkg package is compiled first and that the design asserts its own rules
`timescale 1ns/1ps
module testbench;
  import event_cfg_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock_i;
  logic rst_b_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [15:0] event_i;
  logic rx_error_i;
  logic downshift_strap_i;
  logic irq_pin_o;
  logic [3:0] downshift_retry_limit_o;
  logic downshift_enable_o;
  logic downshift_energy_mode_o;
  logic serial_mac_negotiation_enable_o;
  logic downshift_to_ten_enable_o;
  int mismatches;
  int samples_checked;
  logic [31:0] rd;
  localparam logic [7:0] STATUS_A = 8'h4c;
  localparam logic [7:0] ENABLE_A = 8'h48;
  localparam logic [7:0] CONFIG_A = 8'h50;
  localparam logic [7:0] COUNT_A = 8'h54;
  phy_event_status_and_config #(.STRAP_PACKAGE(1'b0)) phy_event_status_and_config_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .event_i(event_i), .rx_error_i(rx_error_i), .downshift_strap_i(downshift_strap_i),
    .irq_pin_o(irq_pin_o), .downshift_retry_limit_o(downshift_retry_limit_o),
    .downshift_enable_o(downshift_enable_o), .downshift_energy_mode_o(downshift_energy_mode_o),
    .serial_mac_negotiation_enable_o(serial_mac_negotiation_enable_o),
    .downshift_to_ten_enable_o(downshift_to_ten_enable_o)
  );
  // ----------------------------------------
  // clock, verdict and watchdog
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic end_sim();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500000;
    mismatches = mismatches + 1;
    end_sim();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ----------------------------------------
  // bus and stimulus helpers
  // ----------------------------------------
  // request held until waitrequest is sampled low; only the watchdog ends a stuck wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_writedata_i <= {16'h0000, d};
    avs_byteenable_i <= be;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clock_i);
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    bus(1'b0, a, 16'h0000, 4'hf, rd);
  endtask
  // event sources are edge detected, so a short pulse then a settle gap
  task automatic pulse(input logic [15:0] m, input logic err);
    @(posedge clock_i);
    event_i <= m;
    rx_error_i <= err;
    repeat (2) @(posedge clock_i);
    event_i <= 16'h0000;
    rx_error_i <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values();
    check({28'h0000_000, downshift_retry_limit_o}, 32'h0000_0004);
    check({31'h0000_0000, downshift_enable_o}, 32'h0000_0000);
    check({29'h0000_0000, downshift_energy_mode_o, serial_mac_negotiation_enable_o,
           downshift_to_ten_enable_o}, 32'h0000_0007);
    check({31'h0000_0000, irq_pin_o}, 32'h0000_0001);
    rd_reg(CONFIG_A);
    check(rd, 32'h0000_29c7);
    rd_reg(STATUS_A);
    check(rd, 32'h0000_0000);
    rd_reg(8'hfc);
    check(rd, UNMAPPED_READ);
  endtask
  task automatic events_unmasked();
    pulse(16'hffff, 1'b0);
    check({31'h0000_0000, irq_pin_o}, 32'h0000_0001);
    rd_reg(STATUS_A);
    check(rd, 32'h0000_fd7f);
    rd_reg(STATUS_A);
    check(rd, 32'h0000_0000);
    wr(ENABLE_A, 16'hffff);
    rd_reg(ENABLE_A);
    check(rd, 32'h0000_fd7f);
    wr(ENABLE_A, 16'h0001);
    pulse(16'h0002, 1'b0);
    check({31'h0000_0000, irq_pin_o}, 32'h0000_0001);
    pulse(16'h0001, 1'b0);
    check({31'h0000_0000, irq_pin_o}, 32'h0000_0000);
    rd_reg(STATUS_A);
    check(rd, 32'h0000_0003);
    repeat (3) @(posedge clock_i);
    check({31'h0000_0000, irq_pin_o}, 32'h0000_0001);
  endtask
  task automatic config_fields();
    // only the low lane written: bits 7 and 6 drop, upper byte kept
    bus(1'b1, CONFIG_A, 16'h0000, 4'h1, rd);
    rd_reg(CONFIG_A);
    check(rd, 32'h0000_2907);
    for (int k = 0; k < 4; k++) begin
      wr(CONFIG_A, 16'h2000 | 16'(k << 10));
      repeat (2) @(posedge clock_i);
      check({28'h0000_000, downshift_retry_limit_o}, 32'(1 << k));
    end
    check({29'h0000_0000, downshift_energy_mode_o, serial_mac_negotiation_enable_o,
           downshift_to_ten_enable_o}, 32'h0000_0000);
    wr(CONFIG_A, 16'hc3c0);
    rd_reg(CONFIG_A);
    check(rd, 32'h0000_03c7);
    check({31'h0000_0000, downshift_enable_o}, 32'h0000_0001);
    check({31'h0000_0000, irq_pin_o}, 32'h0000_0000);
    pulse(16'h0001, 1'b0);
    check({31'h0000_0000, irq_pin_o}, 32'h0000_0001);
    rd_reg(STATUS_A);
  endtask
  // saturation at all ones would take far too many pulses; the design's own assertion covers it
  task automatic error_count();
    rd_reg(COUNT_A);
    check(rd, 32'h0000_0000);
    for (int k = 0; k < 3; k++) pulse(16'h0000, 1'b1);
    rd_reg(COUNT_A);
    check(rd, 32'h0000_0003);
    wr(COUNT_A, 16'h1234);
    rd_reg(COUNT_A);
    check(rd, 32'h0000_0000);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst_b_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hf;
    event_i = 16'h0000;
    rx_error_i = 1'b0;
    downshift_strap_i = 1'b1;
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    reset_values();
    events_unmasked();
    config_fields();
    error_count();
    end_sim();
  end
endmodule
